//--- rtl/ptc_pkg.sv
// package: offsets, field positions, encodings and reset values
package ptc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CNTL_OFS = 8'h08;
  localparam logic [7:0] CNTH_OFS = 8'h0c;
  localparam logic [7:0] CMPAL_OFS = 8'h10;
  localparam logic [7:0] CMPAH_OFS = 8'h14;
  localparam logic [7:0] PERL_OFS = 8'h18;
  localparam logic [7:0] PERH_OFS = 8'h1c;
  // control_reg_zero fields
  localparam int C0_PAUSE = 7;
  localparam int C0_CK_LSB = 4;
  localparam int C0_ON = 3;
  // control_reg_one fields
  localparam int C1_MODE_LSB = 6;
  localparam int C1_IO_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_CAPTS = 1;
  localparam int C1_CCLR = 0;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] VAL_RST = 10'h000;
  // mode_field codes
  localparam logic [1:0] MD_CMP = 2'h0;
  localparam logic [1:0] MD_CAP = 2'h1;
  localparam logic [1:0] MD_PWM = 2'h2;
  localparam logic [1:0] MD_TMR = 2'h3;
  // clock_select_field codes
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;
  // prescaler terminal counts
  localparam logic [1:0] SYS4_LAST = 2'h3;
  localparam logic [3:0] H16_LAST = 4'hf;
  localparam logic [5:0] H64_LAST = 6'h3f;
endpackage

//--- rtl/ptc_edge_if.sv
// interface: raw pin in, synchronised level and edge pulses out
`timescale 1ns/10ps
`default_nettype none
interface ptc_edge_if;
  logic raw;
  logic lvl;
  logic rise;
  logic fall;
  modport det (input raw, output lvl, rise, fall);
  modport user (output raw, input lvl, rise, fall);
endinterface
`default_nettype wire

//--- rtl/ptc_edge.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module ptc_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and edges
  ptc_edge_if.det e
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first flop only feeds the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= e.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // one pulse per qualifying edge
  assign e.lvl = s2_q;
  assign e.rise = s2_q & ~s3_q;
  assign e.fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

//--- rtl/ptc_timer.sv
// periodic timer channel with apb registers
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ptc_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock enables from the clock generator
  input wire logic high_clk_tick,
  input wire logic sub_clk_tick,
  // pins
  input wire logic ext_clock_pin,
  input wire logic capture_pin,
  output logic timer_out_pin,
  output logic timer_out_inv_pin,
  // interrupt requests
  output logic int_a_pulse,
  output logic int_p_pulse
);
  logic pause_q;
  logic [2:0] ck_q;
  logic on_q;
  logic [7:0] c1_q;
  logic [9:0] cnt_q;
  logic [9:0] compare_a_value_q;
  logic [9:0] period_compare_value_q;
  logic [7:0] hold_q;
  logic out_q;
  logic out_d;
  logic pin_q;
  logic pinb_q;
  logic pulse_q;
  logic [1:0] pre_q;
  logic [5:0] hdiv_q;
  logic [31:0] prdata_q;
  logic int_a_q;
  logic int_p_q;

  // pin synchronisers, one per input pin
  ptc_edge_if ext_e ();
  ptc_edge_if cap_e ();
  assign ext_e.raw = ext_clock_pin;
  assign cap_e.raw = capture_pin;
  ptc_edge u_ext (.clk(pclk), .rst_n(presetn), .e(ext_e));
  ptc_edge u_cap (.clk(pclk), .rst_n(presetn), .e(cap_e));

  // bus phase and address decode
  wire setup_w = psel & ~penable;
  wire acc_w = psel & penable;
  wire wr_w = acc_w & pwrite;
  wire rd_w = acc_w & ~pwrite;
  wire sel_c0 = paddr == ptc_pkg::CTRL0_OFS;
  wire sel_c1 = paddr == ptc_pkg::CTRL1_OFS;
  wire sel_dl = paddr == ptc_pkg::CNTL_OFS;
  wire sel_dh = paddr == ptc_pkg::CNTH_OFS;
  wire sel_al = paddr == ptc_pkg::CMPAL_OFS;
  wire sel_ah = paddr == ptc_pkg::CMPAH_OFS;
  wire sel_pl = paddr == ptc_pkg::PERL_OFS;
  wire sel_ph = paddr == ptc_pkg::PERH_OFS;
  wire hit_w = sel_c0 | sel_c1 | sel_dl | sel_dh | sel_al | sel_ah |
               sel_pl | sel_ph;
  wire sel_low = sel_dl | sel_al | sel_pl;

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc_w & ~hit_w;
  assign prdata = prdata_q;

  // read mux; low bytes come from the buffer, not the live value
  wire [7:0] c0_rd = {pause_q, ck_q, on_q, 3'h0};
  wire [7:0] rd_val_w =
    sel_c0 ? c0_rd :
    sel_c1 ? c1_q :
    sel_low ? hold_q :
    sel_dh ? {6'h00, cnt_q[9:8]} :
    sel_ah ? {6'h00, compare_a_value_q[9:8]} :
    sel_ph ? {6'h00, period_compare_value_q[9:8]} : 8'h00;

  // control fields
  wire [1:0] mode_w = c1_q[ptc_pkg::C1_MODE_LSB +: 2];
  wire [1:0] io_w = c1_q[ptc_pkg::C1_IO_LSB +: 2];
  wire oc_w = c1_q[ptc_pkg::C1_OC];
  wire pol_w = c1_q[ptc_pkg::C1_POL];
  wire capts_w = c1_q[ptc_pkg::C1_CAPTS];
  wire cclr_w = c1_q[ptc_pkg::C1_CCLR];
  wire on_rise_w = wr_w & sel_c0 & pwdata[ptc_pkg::C0_ON] & ~on_q;
  wire run_w = on_q & ~pause_q;
  wire md_cmp = mode_w == ptc_pkg::MD_CMP;
  wire md_cap = mode_w == ptc_pkg::MD_CAP;
  wire md_pwm = mode_w == ptc_pkg::MD_PWM;

  // count clock selection as enables on pclk
  wire sys4_w = pre_q == ptc_pkg::SYS4_LAST;
  wire h16_w = high_clk_tick & (hdiv_q[3:0] == ptc_pkg::H16_LAST);
  wire h64_w = high_clk_tick & (hdiv_q == ptc_pkg::H64_LAST);
  wire tick_w =
    (ck_q == ptc_pkg::CK_SYS4) ? sys4_w :
    (ck_q == ptc_pkg::CK_SYS) ? 1'b1 :
    (ck_q == ptc_pkg::CK_H16) ? h16_w :
    (ck_q == ptc_pkg::CK_H64) ? h64_w :
    (ck_q == ptc_pkg::CK_EXTR) ? ext_e.rise :
    (ck_q == ptc_pkg::CK_EXTF) ? ext_e.fall : sub_clk_tick;

  // capture source and active edge
  wire crise_w = capts_w ? ext_e.rise : cap_e.rise;
  wire cfall_w = capts_w ? ext_e.fall : cap_e.fall;
  wire cap_ev_w = run_w & md_cap &
    ((io_w == 2'h0 & crise_w) | (io_w == 2'h1 & cfall_w) |
     (io_w == 2'h2 & (crise_w | cfall_w)));

  // single pulse trigger from the external clock pin
  wire sp_w = md_pwm & (io_w == 2'h3);
  wire trig_w = on_q & sp_w & ext_e.rise;

  // comparators against the live counter
  wire cnt_step = tick_w & run_w;
  wire match_a_w = cnt_step & ~md_cap & (cnt_q == compare_a_value_q);
  wire match_p_w = cnt_step & (cnt_q == period_compare_value_q);
  wire clr_w = cclr_w ? match_a_w : match_p_w;
  wire pwm_act_w = cnt_q < compare_a_value_q;

  // prescalers; the high divider only moves on its own tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 2'h0;
      hdiv_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 2'h1;
      if (high_clk_tick)
        hdiv_q <= hdiv_q + 6'h01;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_q <= ptc_pkg::CTRL0_RST[ptc_pkg::C0_PAUSE];
      ck_q <= ptc_pkg::CTRL0_RST[ptc_pkg::C0_CK_LSB +: 3];
      on_q <= ptc_pkg::CTRL0_RST[ptc_pkg::C0_ON];
      c1_q <= ptc_pkg::CTRL1_RST;
    end else begin
      if (wr_w & sel_c0) begin
        pause_q <= pwdata[ptc_pkg::C0_PAUSE];
        ck_q <= pwdata[ptc_pkg::C0_CK_LSB +: 3];
        on_q <= pwdata[ptc_pkg::C0_ON];
      end
      if (wr_w & sel_c1)
        c1_q <= pwdata[7:0];
    end
  end

  // shared low-byte buffer, one per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 8'h00;
    end else if (wr_w & (sel_al | sel_pl)) begin
      hold_q <= pwdata[7:0];
    end else if (rd_w & sel_dh) begin
      hold_q <= cnt_q[7:0];
    end else if (rd_w & sel_ah) begin
      hold_q <= compare_a_value_q[7:0];
    end else if (rd_w & sel_ph) begin
      hold_q <= period_compare_value_q[7:0];
    end
  end

  // comparator values; a capture takes priority over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_value_q <= ptc_pkg::VAL_RST;
      period_compare_value_q <= ptc_pkg::VAL_RST;
    end else begin
      if (cap_ev_w)
        compare_a_value_q <= cnt_q;
      else if (wr_w & sel_ah)
        compare_a_value_q <= {pwdata[1:0], hold_q};
      if (wr_w & sel_ph)
        period_compare_value_q <= {pwdata[1:0], hold_q};
    end
  end

  // up counter; 10-bit wrap is the overflow clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= ptc_pkg::VAL_RST;
    end else if (on_rise_w | trig_w) begin
      cnt_q <= 10'h000;
    end else if (cnt_step) begin
      cnt_q <= clr_w ? 10'h000 : cnt_q + 10'h001;
    end
  end

  // output level per mode; timer mode only sets the level to oc_w when counting is switched on
  always_comb begin
    out_d = out_q;
    if (on_rise_w) begin
      out_d = oc_w;
    end else if (md_cmp) begin
      if (match_a_w) begin
        case (io_w)
          2'h1: out_d = 1'b0;
          2'h2: out_d = 1'b1;
          2'h3: out_d = ~out_q;
          default: out_d = out_q;
        endcase
      end
    end else if (md_pwm & on_q) begin
      case (io_w)
        2'h0: out_d = ~oc_w;
        2'h1: out_d = oc_w;
        2'h2: out_d = pwm_act_w ? oc_w : ~oc_w;
        default: out_d = (pulse_q | trig_w) ? oc_w : ~oc_w;
      endcase
    end
  end

  // pulse span, bus read data and interrupt pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      int_a_q <= 1'b0;
      int_p_q <= 1'b0;
    end else begin
      if (trig_w)
        pulse_q <= 1'b1;
      else if (match_a_w | on_rise_w | ~sp_w)
        pulse_q <= 1'b0;
      if (setup_w)
        prdata_q <= {24'h000000, rd_val_w};
      int_a_q <= match_a_w | cap_ev_w;
      int_p_q <= match_p_w;
    end
  end

  // pins come from one flop pair so they never disagree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      pin_q <= 1'b0;
      pinb_q <= 1'b1;
    end else begin
      out_q <= out_d;
      pin_q <= out_d ^ pol_w;
      pinb_q <= ~(out_d ^ pol_w);
    end
  end

  assign timer_out_pin = pin_q;
  assign timer_out_inv_pin = pinb_q;
  assign int_a_pulse = int_a_q;
  assign int_p_pulse = int_p_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_match_a;
    match_a_w & md_cmp & ~on_rise_w;
  endsequence
  sequence s_wr_high;
    wr_w & sel_ah & ~cap_ev_w;
  endsequence

  pin_compl_a: assert property (
    timer_out_inv_pin == ~timer_out_pin)
    else $error("inverted pin not complement");
  low_write_a: assert property (
    wr_w & sel_al |=> hold_q == $past(pwdata[7:0]) && $stable(compare_a_value_q))
    else $error("low write reached low byte");
  high_write_a: assert property (
    s_wr_high |=> compare_a_value_q == {$past(pwdata[1:0]), $past(hold_q)})
    else $error("high write did not merge buffer");
  high_read_a: assert property (
    rd_w & sel_dh |=> hold_q == $past(cnt_q[7:0]))
    else $error("high read did not latch low byte");
  low_read_a: assert property (
    setup_w & ~pwrite & sel_al |=> prdata[7:0] == $past(hold_q))
    else $error("low read not from buffer");
  on_clear_a: assert property (
    on_rise_w |=> cnt_q == 10'h000 && out_q == $past(oc_w))
    else $error("counter on did not clear");
  int_a_out_a: assert property (
    match_a_w |=> int_a_pulse ##1 !int_a_pulse || $past(match_a_w))
    else $error("match a interrupt missing");
  cmp_set_a: assert property (
    s_match_a ##0 io_w == 2'h2 |=> timer_out_pin == ~$past(pol_w))
    else $error("compare set did not drive high");
  ext_edge_a: assert property (
    ck_q == ptc_pkg::CK_EXTF |-> tick_w == ($past(ext_e.lvl) & ~ext_e.lvl))
    else $error("falling edge clock mismatch");
  cap_take_a: assert property (
    cap_ev_w |=> compare_a_value_q == $past(cnt_q) && int_a_pulse)
    else $error("capture not taken");

  // period side, trigger and counter stepping
  int_p_out_a: assert property (
    match_p_w |=> int_p_pulse)
    else $error("period interrupt missing");
  per_read_a: assert property (
    rd_w & sel_ph |=> hold_q == $past(period_compare_value_q[7:0]))
    else $error("period high read did not latch low byte");
  sp_trig_a: assert property (
    trig_w |=> cnt_q == 10'h000 &&
      timer_out_pin == ($past(oc_w) ^ $past(pol_w)))
    else $error("pulse trigger did not start");
  cnt_up_a: assert property (
    cnt_step & ~clr_w & ~on_rise_w & ~trig_w |=>
      cnt_q == $past(cnt_q) + 10'h001)
    else $error("counter did not step up");
  per_clear_a: assert property (
    match_p_w & ~cclr_w & ~on_rise_w & ~trig_w |=> cnt_q == 10'h000)
    else $error("period match did not clear");
endmodule
`default_nettype wire

//--- sim/test_ptc_timer.sv
// bench for the periodic timer channel: apb tasks and directed tests
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_ptc_timer;
  logic pclk, presetn, psel, penable, pwrite, high_clk_tick, sub_clk_tick;
  logic ext_clock_pin, capture_pin, ext_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, timer_out_pin, timer_out_inv_pin, err;
  logic int_a_pulse, int_p_pulse;
  logic [1:0] tc;
  int errors, total_checks, gap, hi, n;
  int exp_gap [8] = '{16, 4, 128, 512, 16, 16, 32, 32};
  ptc_timer uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_clk_tick(high_clk_tick),
    .sub_clk_tick(sub_clk_tick), .ext_clock_pin(ext_clock_pin),
    .capture_pin(capture_pin), .timer_out_pin(timer_out_pin),
    .timer_out_inv_pin(timer_out_inv_pin), .int_a_pulse(int_a_pulse),
    .int_p_pulse(int_p_pulse));
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  // tick enables: high every 2 cycles, sub every 4; ext pin runs on demand
  always @(posedge pclk) begin
    tc <= tc + 2'h1;
    high_clk_tick <= ~high_clk_tick;
    sub_clk_tick <= (tc == 2'h3);
    if (ext_run && tc == 2'h3) ext_clock_pin <= ~ext_clock_pin;
  end
  // the complement pin is watched on the falling edge, away from updates
  always @(negedge pclk)
    if (presetn) `CHK("inv_pin", ~timer_out_pin, timer_out_inv_pin)
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("prdata", e, rd)
  endtask
  task automatic wpair(input logic [7:0] lo, input logic [7:0] hi_a,
                       input logic [9:0] v);
    apb(1'b1, lo, v[7:0]);
    apb(1'b1, hi_a, {6'h0, v[9:8]});
  endtask
  // restart counter with the given clock source; on rising clears the count
  task automatic start(input logic [2:0] ck, input logic [7:0] c1);
    apb(1'b1, ptc_pkg::CTRL0_OFS, 8'h00);
    apb(1'b1, ptc_pkg::CTRL1_OFS, c1);
    apb(1'b1, ptc_pkg::CTRL0_OFS, {1'b0, ck, 1'b1, 3'h0});
  endtask
  // cycles between two period pulses, and cycles with the pin high in them
  task automatic meas();
    n = 0;
    while (int_p_pulse !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
    gap = 0; hi = 0;
    do begin @(posedge pclk); gap++; hi += (timer_out_pin === 1'b1); end
    while (int_p_pulse !== 1'b1 && gap < 3000);
  endtask
  // one pin edge, then count comparator a pulses for a few cycles
  task automatic cap_edge(input logic src, input logic v, input logic e);
    @(posedge pclk);
    if (src) ext_clock_pin <= v; else capture_pin <= v;
    n = 0;
    repeat (8) begin @(posedge pclk); n += (int_a_pulse === 1'b1); end
    `CHK("cap_pulse", e, n == 1)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; high_clk_tick = 0; sub_clk_tick = 0; tc = 2'h0;
    ext_clock_pin = 0; capture_pin = 0; ext_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ptc_pkg::CTRL0_OFS, 32'h0);
    rchk(ptc_pkg::CTRL1_OFS, 32'h0);
    `CHK("out_rst", 1'b0, timer_out_pin)
    // buffered byte access: low write lands in the buffer only
    apb(1'b1, ptc_pkg::CMPAL_OFS, 8'ha5);
    rchk(ptc_pkg::PERL_OFS, 32'ha5);
    rchk(ptc_pkg::CMPAH_OFS, 32'h0);
    rchk(ptc_pkg::CMPAL_OFS, 32'h0);
    wpair(ptc_pkg::CMPAL_OFS, ptc_pkg::CMPAH_OFS, 10'h2a5);
    wpair(ptc_pkg::PERL_OFS, ptc_pkg::PERH_OFS, 10'h13c);
    rchk(ptc_pkg::CMPAH_OFS, 32'h2);
    rchk(ptc_pkg::CMPAL_OFS, 32'ha5);
    rchk(ptc_pkg::PERH_OFS, 32'h1);
    rchk(ptc_pkg::PERL_OFS, 32'h3c);
    apb(1'b0, 8'h40, 8'h00);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    `CHK("pready", 1'b1, pready)
    // every clock source, period 3 gives four counts per period
    wpair(ptc_pkg::PERL_OFS, ptc_pkg::PERH_OFS, 10'h003);
    for (int k = 0; k < 8; k++) begin
      ext_run <= (k >= 6);
      start(k[2:0], {ptc_pkg::MD_TMR, 6'h00});
      meas();
      `CHK("clk_gap", exp_gap[k], gap)
    end
    // park the ext pin low so later tests see a clean rising edge
    ext_run <= 1'b0;
    @(posedge pclk);
    ext_clock_pin <= 1'b0;
    // compare output: pin level after first comparator a match per io code
    wpair(ptc_pkg::CMPAL_OFS, ptc_pkg::CMPAH_OFS, 10'h002);
    for (int io = 0; io < 4; io++) begin
      start(ptc_pkg::CK_SYS, {ptc_pkg::MD_CMP, io[1:0], io < 2, 3'h0});
      @(negedge pclk);
      `CHK("cmp_init", io < 2, timer_out_pin)
      n = 0;
      while (int_a_pulse !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
      `CHK("cmp_int_a", 1'b1, int_a_pulse)
      @(posedge pclk);
      `CHK("cmp_pin", io != 1, timer_out_pin)
    end
    // pwm: duty of 1 in 4, inverted by polarity
    wpair(ptc_pkg::CMPAL_OFS, ptc_pkg::CMPAH_OFS, 10'h001);
    for (int p = 0; p < 2; p++) begin
      start(ptc_pkg::CK_SYS, {ptc_pkg::MD_PWM, 2'h2, 1'b1, p[0], 2'h0});
      meas();
      `CHK("pwm_gap", 4, gap)
      `CHK("pwm_high", p ? 3 : 1, hi)
    end
    // single pulse started by the ext clock pin
    wpair(ptc_pkg::PERL_OFS, ptc_pkg::PERH_OFS, 10'h3ff);
    wpair(ptc_pkg::CMPAL_OFS, ptc_pkg::CMPAH_OFS, 10'h005);
    start(ptc_pkg::CK_SYS, {ptc_pkg::MD_PWM, 2'h3, 1'b1, 3'h0});
    repeat (10) @(posedge pclk);
    `CHK("sp_idle", 1'b0, timer_out_pin)
    ext_clock_pin <= 1'b1;
    hi = 0;
    repeat (40) begin @(posedge pclk); hi += (timer_out_pin === 1'b1); end
    `CHK("sp_width", 1'b1, hi >= 5 && hi <= 7)
    ext_clock_pin <= 1'b0;
    // capture: each edge selection from both sources
    for (int io = 0; io < 4; io++) begin
      for (int s = 0; s < 2; s++) begin
        start(ptc_pkg::CK_SYS, {ptc_pkg::MD_CAP, io[1:0], 2'h0, s[0], 1'b0});
        cap_edge(s[0], 1'b1, io == 0 || io == 2);
        cap_edge(s[0], 1'b0, io == 1 || io == 2);
      end
    end
    // counter read: paused at zero, buffer first loaded with other data
    apb(1'b1, ptc_pkg::CTRL0_OFS, 8'h00);
    apb(1'b1, ptc_pkg::CTRL0_OFS, {1'b1, ptc_pkg::CK_SYS, 1'b1, 3'h0});
    apb(1'b1, ptc_pkg::CMPAL_OFS, 8'h5a);
    rchk(ptc_pkg::CNTH_OFS, 32'h0);
    rchk(ptc_pkg::CNTL_OFS, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
